/* hw/ltmc_pkg.sv */
// Shared constants and types of the transceiver mode control block
package ltmc_pkg;
  localparam int CHANNELS = 2;
  // Transceiver mode encodings
  typedef enum logic [1:0] {
    LTMC_MODE_OFF    = 2'h0,
    LTMC_MODE_WAKE   = 2'h1,
    LTMC_MODE_RXONLY = 2'h2,
    LTMC_MODE_NORMAL = 2'h3
  } ltmc_mode_e;
  // Host chip operating modes
  typedef enum logic [2:0] {
    LTMC_CHIP_NORMAL   = 3'h0,
    LTMC_CHIP_STOP     = 3'h1,
    LTMC_CHIP_SLEEP    = 3'h2,
    LTMC_CHIP_RESTART  = 3'h3,
    LTMC_CHIP_FAILSAFE = 3'h4
  } ltmc_chip_e;
  localparam int  CLK_MHZ         = 125;
  localparam int  EN_TIME_US      = 10;
  localparam int  WAKE_FILT_US    = 30;
  localparam int  TX_TO_US        = 12000;
  localparam int  BUS_TO_US       = 12000;
  localparam int  EN_CYC          = EN_TIME_US * CLK_MHZ;
  localparam int  WAKE_CYC        = WAKE_FILT_US * CLK_MHZ;
  localparam int  TX_TO_CYC       = TX_TO_US * CLK_MHZ;
  localparam int  BUS_TO_CYC      = BUS_TO_US * CLK_MHZ;
  localparam int  CNT_W           = 24;
  localparam int  FIFO_W          = 2;
  localparam int  FIFO_D          = 16;
endpackage

/* hw/ltmc_fifo_if.sv */
// Carrier between the receive sampler and its FIFO
`timescale 1ns/1ps
`default_nettype none
interface ltmc_fifo_if #(parameter int W = 2);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* hw/ltmc_fifo.sv */
// Small FIFO with valid and ready on both sides, registered read data
`timescale 1ns/1ps
`default_nettype none
module ltmc_fifo #(
  parameter int W = 2,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic   clock_in,
  input  wire logic   sys_rst_in,
  // Fill side
  ltmc_fifo_if.snk    wr,
  // Drain side
  output logic         rd_valid_out,
  output logic [W-1:0] rd_data_out,
  input  wire logic    rd_ready_in
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW:0]   wp;
  logic [AW:0]   rp;
  logic          full;
  logic          empty;
  logic          pop;
  assign full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign empty = (wp == rp);
  assign wr.ready = !full;
  // Output register loads whenever the store holds data and the register is empty or being taken
  assign pop = !empty && (!rd_valid_out || rd_ready_in);
  // Write side
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp <= '0;
    end else if (wr.valid && !full) begin
      wp <= wp + 1'b1;
    end
  end
  always_ff @(posedge clock_in) begin
    if (wr.valid && !full) begin
      mem[wp[AW-1:0]] <= wr.data;
    end
  end
  // Read side
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rp           <= '0;
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end else begin
      if (pop) begin
        rp           <= rp + 1'b1;
        rd_data_out  <= mem[rp[AW-1:0]];
        rd_valid_out <= 1'b1;
      end else if (rd_ready_in) begin
        rd_valid_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/ltmc_top.sv */
// Two-channel single-wire bus transceiver mode control logic
`timescale 1ns/1ps
`default_nettype none
module ltmc_top
  import ltmc_pkg::*;
#(
  parameter int TX_TO_CYCLES  = TX_TO_CYC,
  parameter int BUS_TO_CYCLES = BUS_TO_CYC
) (
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                sys_rst_in,
  // Configuration written by the serial port
  input  wire logic [1:0]          channel1_mode_bits_in,
  input  wire logic [1:0]          channel2_mode_bits_in,
  input  wire logic                mode_write_in,
  input  wire logic                low_slope_select_in,
  input  wire logic                flash_select_in,
  input  wire logic                spi_select_n_in,
  input  wire logic                watchdog_on_bus_wake_enable_in,
  input  wire logic                watchdog_disabled_in,
  input  wire logic [2:0]          chip_mode_in,
  input  wire logic                transceiver_supply_uv_in,
  // Controller and bus pins
  input  wire logic [CHANNELS-1:0] bus_tx_input_in,
  input  wire logic [CHANNELS-1:0] bus_level_in,
  output logic [CHANNELS-1:0]      bus_rx_output_out,
  output logic [CHANNELS-1:0]      bus_drive_low_out,
  output logic [CHANNELS-1:0]      receiver_on_out,
  // Status and events
  output logic [1:0]               channel1_mode_bits_out,
  output logic [1:0]               channel2_mode_bits_out,
  output logic                     channel1_failure_flag_out,
  output logic                     channel2_failure_flag_out,
  input  wire logic                fail_clear_in,
  output logic [CHANNELS-1:0]      wake_status_reg_out,
  input  wire logic                wake_clear_in,
  output logic                     int_n_out,
  input  wire logic                int_ack_in,
  output logic                     watchdog_enable_out,
  output logic                     restart_request_out,
  output logic                     low_slope_out,
  output logic                     flash_out,
  // Receive sample stream
  output logic                     rx_sample_valid_out,
  output logic [FIFO_W-1:0]        rx_sample_out,
  input  wire logic                rx_sample_ready_in
);
  // Pin synchronisers
  logic [CHANNELS-1:0] tx_s1, tx_s2, bus_s1, bus_s2;
  logic                cs_s1, cs_s2, cs_d, uv_s1, uv_s2;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_s1  <= '1;
      tx_s2  <= '1;
      bus_s1 <= '1;
      bus_s2 <= '1;
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      cs_d   <= 1'b1;
      uv_s1  <= 1'b0;
      uv_s2  <= 1'b0;
    end else begin
      tx_s1  <= bus_tx_input_in;
      tx_s2  <= tx_s1;
      bus_s1 <= bus_level_in;
      bus_s2 <= bus_s1;
      cs_s1  <= spi_select_n_in;
      cs_s2  <= cs_s1;
      cs_d   <= cs_s2;
      uv_s1  <= transceiver_supply_uv_in;
      uv_s2  <= uv_s1;
    end
  end
  logic cs_rise;
  assign cs_rise = cs_s2 && !cs_d;
  // Chip mode tracking for automatic rearm on entry
  ltmc_chip_e chip, chip_d;
  logic       chip_rearm;
  assign chip = ltmc_chip_e'(chip_mode_in);
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chip_d <= LTMC_CHIP_NORMAL;
    end else begin
      chip_d <= chip;
    end
  end
  assign chip_rearm = (chip != chip_d) && (chip == LTMC_CHIP_STOP ||
                      chip == LTMC_CHIP_SLEEP || chip == LTMC_CHIP_FAILSAFE);
  // Slope and flash, latched on select release in chip normal mode
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      low_slope_out <= 1'b0;
      flash_out     <= 1'b0;
    end else if (cs_rise && chip == LTMC_CHIP_NORMAL) begin
      low_slope_out <= low_slope_select_in;
      flash_out     <= flash_select_in;
    end
  end
  logic [1:0]          wr_mode [CHANNELS];
  logic [CHANNELS-1:0] wake_ev;
  logic [CHANNELS-1:0] fail_set;
  ltmc_mode_e          mode [CHANNELS];
  assign wr_mode[0] = channel1_mode_bits_in;
  assign wr_mode[1] = channel2_mode_bits_in;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      ltmc_mode_e        req;
      logic              allowed, armed, woken, en_done, tx_armed, tx_to;
      logic [CNT_W-1:0]  en_cnt, tx_cnt, bus_cnt, wk_cnt;
      assign req = ltmc_mode_e'(wr_mode[g]);
      // Which requests the chip mode admits
      always_comb begin
        unique case (req)
          LTMC_MODE_NORMAL, LTMC_MODE_RXONLY: allowed = (chip == LTMC_CHIP_NORMAL ||
                                                 chip == LTMC_CHIP_STOP);
          LTMC_MODE_WAKE: allowed = (chip != LTMC_CHIP_FAILSAFE);
          LTMC_MODE_OFF: allowed = 1'b1;
        endcase
      end
      // Mode register; fail-safe forces wake capable
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          mode[g] <= LTMC_MODE_OFF;
        end else if (chip == LTMC_CHIP_FAILSAFE) begin
          mode[g] <= LTMC_MODE_WAKE;
        end else if (mode_write_in && allowed) begin
          mode[g] <= req;
        end
      end
      // Wake arming: leaving wake mode or chip entry rearms
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          armed <= 1'b1;
          woken <= 1'b0;
        end else if (mode[g] != LTMC_MODE_WAKE || chip_rearm) begin
          armed <= 1'b1;
          woken <= (mode[g] == LTMC_MODE_WAKE) ? woken : 1'b0;
          if (chip_rearm) woken <= woken;
        end else if (wake_ev[g]) begin
          armed <= 1'b0;
          woken <= 1'b1;
        end
      end
      // Wake filter: dominant longer than the filter time
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          wk_cnt <= '0;
        end else if (bus_s2[g] || mode[g] != LTMC_MODE_WAKE) begin
          wk_cnt <= '0;
        end else if (wk_cnt != CNT_W'(WAKE_CYC)) begin
          wk_cnt <= wk_cnt + 1'b1;
        end
      end
      assign wake_ev[g] = armed && mode[g] == LTMC_MODE_WAKE && !uv_s2 &&
                          wk_cnt == CNT_W'(WAKE_CYC - 1);
      // Enabling time after entering normal mode
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          en_cnt  <= '0;
          en_done <= 1'b0;
        end else if (mode[g] != LTMC_MODE_NORMAL) begin
          en_cnt  <= '0;
          en_done <= 1'b0;
        end else if (en_cnt != CNT_W'(EN_CYC)) begin
          en_cnt <= en_cnt + 1'b1;
        end else begin
          en_done <= 1'b1;
        end
      end
      // Only a dominant that starts after enabling is sent
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          tx_armed <= 1'b0;
        end else if (!en_done) begin
          tx_armed <= 1'b0;
        end else if (tx_s2[g]) begin
          tx_armed <= 1'b1;
        end
      end
      // Transmit dominant time-out; released once recessive
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          tx_cnt <= '0;
          tx_to  <= 1'b0;
        end else if (tx_s2[g]) begin
          tx_cnt <= '0;
          tx_to  <= 1'b0;
        end else if (tx_cnt == CNT_W'(TX_TO_CYCLES)) begin
          tx_to <= 1'b1;
        end else begin
          tx_cnt <= tx_cnt + 1'b1;
        end
      end
      // Bus dominant clamp in any mode
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          bus_cnt <= '0;
        end else if (bus_s2[g]) begin
          bus_cnt <= '0;
        end else if (bus_cnt != CNT_W'(BUS_TO_CYCLES)) begin
          bus_cnt <= bus_cnt + 1'b1;
        end
      end
      assign fail_set[g] = (tx_cnt == CNT_W'(TX_TO_CYCLES) && !tx_to) ||
                           (bus_cnt == CNT_W'(BUS_TO_CYCLES - 1));
      // Pin outputs; undervoltage suspends both stages
      always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          bus_drive_low_out[g] <= 1'b0;
          bus_rx_output_out[g] <= 1'b1;
          receiver_on_out[g]   <= 1'b0;
        end else begin
          bus_drive_low_out[g] <= mode[g] == LTMC_MODE_NORMAL && !uv_s2 && tx_armed &&
                                  !tx_s2[g] && !tx_to;
          receiver_on_out[g]   <= !uv_s2 && (mode[g] == LTMC_MODE_NORMAL ||
                                  mode[g] == LTMC_MODE_RXONLY);
          if (mode[g] == LTMC_MODE_WAKE) begin
            bus_rx_output_out[g] <= !(woken || wake_ev[g]);
          end else if (receiver_on_out[g]) begin
            bus_rx_output_out[g] <= bus_s2[g];
          end else begin
            bus_rx_output_out[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate
  assign channel1_mode_bits_out = mode[0];
  assign channel2_mode_bits_out = mode[1];
  // Failure flags and wake status: set wins over clear
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      channel1_failure_flag_out <= 1'b0;
      channel2_failure_flag_out <= 1'b0;
      wake_status_reg_out       <= '0;
    end else begin
      channel1_failure_flag_out <= fail_set[0] ||
                                   (channel1_failure_flag_out && !fail_clear_in);
      channel2_failure_flag_out <= fail_set[1] ||
                                   (channel2_failure_flag_out && !fail_clear_in);
      wake_status_reg_out <= wake_ev | (wake_status_reg_out &
                             {CHANNELS{!wake_clear_in}});
    end
  end
  // Chip-level reactions to a wake
  logic any_wake;
  assign any_wake = |wake_ev;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      int_n_out           <= 1'b1;
      watchdog_enable_out <= 1'b0;
      restart_request_out <= 1'b0;
    end else begin
      if (any_wake && (chip == LTMC_CHIP_STOP || chip == LTMC_CHIP_NORMAL)) begin
        int_n_out <= 1'b0;
      end else if (int_ack_in) begin
        int_n_out <= 1'b1;
      end
      watchdog_enable_out <= any_wake && chip == LTMC_CHIP_STOP &&
                             watchdog_disabled_in && watchdog_on_bus_wake_enable_in;
      restart_request_out <= any_wake && (chip == LTMC_CHIP_SLEEP ||
                             chip == LTMC_CHIP_RESTART ||
                             chip == LTMC_CHIP_FAILSAFE);
    end
  end
  // Receive samples stream through the FIFO; full stalls sampling and keeps only the level present when space returns, if it differs from the last sample
  ltmc_fifo_if #(.W(FIFO_W)) smp ();
  logic [CHANNELS-1:0] rx_last;
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_last <= '1;
    end else if (smp.ready) begin
      rx_last <= bus_rx_output_out;
    end
  end
  assign smp.valid = (bus_rx_output_out != rx_last);
  assign smp.data  = bus_rx_output_out;
  ltmc_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clock_in     (clock_in),
    .sys_rst_in   (sys_rst_in),
    .wr           (smp),
    .rd_valid_out (rx_sample_valid_out),
    .rd_data_out  (rx_sample_out),
    .rd_ready_in  (rx_sample_ready_in)
  );
  // Assertions
  wake_int_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    any_wake && chip == LTMC_CHIP_STOP |=> !int_n_out)
    else $error("stop wake did not pull interrupt low");
  sleep_noint_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    any_wake && chip == LTMC_CHIP_SLEEP && int_n_out |=> int_n_out && restart_request_out)
    else $error("sleep wake raised interrupt or no restart");
  wake_rx_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wake_ev[0] |=> !bus_rx_output_out[0] && mode[0] == LTMC_MODE_WAKE)
    else $error("wake did not drive receive low");
  uv_quiet_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    uv_s2 |=> bus_drive_low_out == '0 && receiver_on_out == '0)
    else $error("stages active under undervoltage");
  failsafe_wake_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    chip == LTMC_CHIP_FAILSAFE |=> mode[1] == LTMC_MODE_WAKE)
    else $error("fail-safe did not force wake mode");
  off_nodrive_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    mode[0] != LTMC_MODE_NORMAL |=> !bus_drive_low_out[0])
    else $error("driver active outside normal mode");
  txto_release_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    g_ch[0].tx_to |=> !bus_drive_low_out[0])
    else $error("driver active after transmit time-out");
  fail_sticky_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fail_set[0] |=> channel1_failure_flag_out)
    else $error("failure flag not set");
  slope_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !cs_rise |=> $stable(low_slope_out) && $stable(flash_out))
    else $error("slope changed without select release");
endmodule
`default_nettype wire

/* tb/ltmc_mcu_model.sv */
// Controller-side model: drives the transmit pins of both channels
`timescale 1ns/1ps
`default_nettype none
module ltmc_mcu_model
  import ltmc_pkg::*;
#(
  parameter int GUARD = EN_CYC + 8
) (
  // Clock and reset
  input  wire logic                clock_in,
  input  wire logic                sys_rst_in,
  // Requests from the bench
  input  wire logic [CHANNELS-1:0] start_in,
  input  wire logic [CHANNELS-1:0] tx_req_in,
  input  wire logic [CHANNELS-1:0] early_low_in,
  // Transmit pins
  output logic [CHANNELS-1:0]      tx_out
);
  int guard [CHANNELS];

  // Enabling window per channel, restarted by each normal-mode write
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (sys_rst_in) guard[i] <= 0;
      else if (start_in[i]) guard[i] <= GUARD;
      else if (guard[i] > 0) guard[i] <= guard[i] - 1;
    end
  end

  // Recessive inside the window; early_low breaks that only when asked
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      if (early_low_in[i]) tx_out[i] = 1'b0;
      else if (guard[i] > 0) tx_out[i] = 1'b1;
      else tx_out[i] = tx_req_in[i];
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the transceiver mode control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ltmc_pkg::*;
  localparam int TO = 200;
  localparam int WK = WAKE_CYC + 60;
  logic       clock_in, sys_rst_in, wr, lss, fls, spi_select_n, wd_on, wd_dis, uv;
  logic       fclr, wclr, ack, rdy, f1, f2, int_n, wde, rrq, lso, flo, sv;
  logic [1:0] m1, m2, mo1, mo2, ext, req, early, start, tx, lvl, rx, drv, rxon, ws, smp;
  logic [2:0] chip;
  logic [1:0] d17, dlast;
  int         miscompares, compares, seed, rcnt, wcnt, n;
  logic [31:0] r;

  // Bus wire: pulled up, low while the driver or a far node pulls it
  assign lvl = ~(drv | ext);

  ltmc_mcu_model ltmc_mcu_model_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .start_in(start), .tx_req_in(req), .early_low_in(early), .tx_out(tx));

  ltmc_top #(.TX_TO_CYCLES(TO), .BUS_TO_CYCLES(TO)) ltmc_top_inst (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .channel1_mode_bits_in(m1), .channel2_mode_bits_in(m2), .mode_write_in(wr),
    .low_slope_select_in(lss), .flash_select_in(fls), .spi_select_n_in(spi_select_n),
    .watchdog_on_bus_wake_enable_in(wd_on), .watchdog_disabled_in(wd_dis),
    .chip_mode_in(chip), .transceiver_supply_uv_in(uv),
    .bus_tx_input_in(tx), .bus_level_in(lvl), .bus_rx_output_out(rx),
    .bus_drive_low_out(drv), .receiver_on_out(rxon),
    .channel1_mode_bits_out(mo1), .channel2_mode_bits_out(mo2),
    .channel1_failure_flag_out(f1), .channel2_failure_flag_out(f2),
    .fail_clear_in(fclr), .wake_status_reg_out(ws), .wake_clear_in(wclr),
    .int_n_out(int_n), .int_ack_in(ack), .watchdog_enable_out(wde),
    .restart_request_out(rrq), .low_slope_out(lso), .flash_out(flo),
    .rx_sample_valid_out(sv), .rx_sample_out(smp), .rx_sample_ready_in(rdy));

  // Clock at 125 MHz
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // One-cycle pulses are counted, since they stand for one cycle only
  always @(posedge clock_in) begin
    if (rrq === 1'b1) rcnt++;
    if (wde === 1'b1) wcnt++;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clock_in);
  endtask

  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Mode write; the controller model opens its window on normal mode
  task automatic wmode(input logic [1:0] a, input logic [1:0] b);
    m1 <= a;
    m2 <= b;
    wr <= 1'b1;
    start <= {b == LTMC_MODE_NORMAL, a == LTMC_MODE_NORMAL};
    cyc(1);
    wr <= 1'b0;
    start <= 2'b00;
    cyc(2);
  endtask

  // Far node holds the bus dominant, then lets go
  task automatic dom(input logic [1:0] e, input int k);
    ext <= e;
    cyc(k);
    ext <= 2'b00;
    cyc(8);
  endtask

  task automatic txb(input logic [1:0] v, input int k);
    req <= v;
    cyc(k);
  endtask

  // Acknowledge and clear every sticky indication at once
  task automatic clr();
    {ack, wclr, fclr} <= 3'h7;
    cyc(1);
    {ack, wclr, fclr} <= 3'h0;
    cyc(2);
  endtask

  // Chip-select pulse carrying the slope and flash bits
  task automatic sel(input logic s, input logic f);
    logic [1:0] held;
    // Latched bits must not move while select is still low
    held = {lso, flo};
    lss <= s;
    fls <= f;
    spi_select_n <= 1'b0;
    cyc(4);
    check("slope held", {lso, flo}, held);
    spi_select_n <= 1'b1;
    cyc(6);
  endtask

  // Bounded run limit
  initial begin
    cyc(100000);
    miscompares++;
    test_done();
  end

  initial begin
    seed = 32'h88e0;
    {m1, m2, wr, lss, fls, wd_on, wd_dis, uv, fclr, wclr, ack, rdy} = '0;
    {ext, early, start} = '0;
    req = 2'b11;
    spi_select_n = 1'b1;
    chip = LTMC_CHIP_NORMAL;
    {miscompares, compares, rcnt, wcnt} = '0;
    sys_rst_in = 1'b1;
    cyc(12);
    sys_rst_in <= 1'b0;
    cyc(4);
    check("mode1", mo1, LTMC_MODE_OFF);
    check("mode2", mo2, LTMC_MODE_OFF);
    check("rx", rx, 2'b11);
    check("drive", drv, 2'b00);
    check("slope flash", {lso, flo}, 2'b00);
    $display("test reset done");
    // Off mode ignores a wake but still sees the clamp
    dom(2'b11, WK);
    check("rx", rx, 2'b11);
    check("wake", ws, 2'b00);
    check("fail", {f2, f1}, 2'b11);
    check("mode1", mo1, LTMC_MODE_OFF);
    clr();
    chip <= LTMC_CHIP_SLEEP;
    cyc(2);
    wmode(LTMC_MODE_NORMAL, LTMC_MODE_RXONLY);
    check("mode1", mo1, LTMC_MODE_OFF);
    check("mode2", mo2, LTMC_MODE_OFF);
    chip <= LTMC_CHIP_NORMAL;
    $display("test off done");
    // Dominant already present at the end of enabling is not sent
    early <= 2'b01;
    wmode(LTMC_MODE_NORMAL, LTMC_MODE_OFF);
    check("mode1", mo1, LTMC_MODE_NORMAL);
    cyc(EN_CYC + 20);
    check("drive", drv[0], 1'b0);
    early <= 2'b00;
    txb(2'b11, 8);
    txb(2'b10, 8);
    check("drive", drv[0], 1'b1);
    check("rx", rx[0], 1'b0);
    txb(2'b11, 8);
    clr();
    $display("test enable done");
    // Random traffic with the stream stalled, then drained
    wmode(LTMC_MODE_NORMAL, LTMC_MODE_NORMAL);
    cyc(EN_CYC + 20);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      req <= r[1:0];
      ext <= r[3:2];
      cyc(8);
      check("drive", drv, 2'(~r[1:0]));
      check("rx", rx, r[1:0] & ~r[3:2]);
    end
    req <= 2'b11;
    ext <= 2'b00;
    cyc(8);
    // Twenty forced receive changes make sure the stalled FIFO is full
    for (int i = 0; i < 20; i++) begin
      txb({1'b1, i[0]}, 8);
    end
    n = 0;
    d17 = 2'b00;
    dlast = 2'b00;
    rdy <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock_in);
      if (sv === 1'b1) begin
        n++;
        dlast = smp;
        if (n == 17) d17 = smp;
      end
    end
    rdy <= 1'b0;
    // Full store is 17 samples, plus the settled level when it differs from the 17th
    check("fifo count", n == 17 + int'(d17 != 2'b11), 1'b1);
    check("fifo last", dlast, 2'b11);
    check("fifo empty", sv, 1'b0);
    clr();
    $display("test traffic done");
    txb(2'b10, TO + 60);
    check("drive", drv[0], 1'b0);
    check("fail1", f1, 1'b1);
    check("mode1", mo1, LTMC_MODE_NORMAL);
    txb(2'b11, 8);
    txb(2'b10, 8);
    check("drive", drv[0], 1'b1);
    txb(2'b11, 8);
    clr();
    $display("test timeout done");
    wmode(LTMC_MODE_RXONLY, LTMC_MODE_NORMAL);
    req <= 2'b10;
    ext <= 2'b01;
    cyc(8);
    check("drive", drv[0], 1'b0);
    check("rx", rx[0], 1'b0);
    req <= 2'b11;
    ext <= 2'b00;
    cyc(8);
    check("rx", rx[0], 1'b1);
    wmode(LTMC_MODE_NORMAL, LTMC_MODE_NORMAL);
    cyc(EN_CYC + 20);
    uv <= 1'b1;
    txb(2'b10, 8);
    check("drive", drv[0], 1'b0);
    check("receiver", rxon, 2'b00);
    uv <= 1'b0;
    txb(2'b11, 8);
    txb(2'b10, 8);
    check("drive", drv[0], 1'b1);
    check("receiver", rxon, 2'b11);
    txb(2'b11, 8);
    $display("test rxonly uv done");
    sel(1'b1, 1'b1);
    check("slope flash", {lso, flo}, 2'b11);
    chip <= LTMC_CHIP_STOP;
    sel(1'b0, 1'b0);
    check("slope flash", {lso, flo}, 2'b11);
    chip <= LTMC_CHIP_NORMAL;
    sel(1'b0, 1'b0);
    check("slope flash", {lso, flo}, 2'b00);
    $display("test slope done");
    // Wake in chip normal, disarm, then rearm by toggling the mode
    wmode(LTMC_MODE_WAKE, LTMC_MODE_OFF);
    dom(2'b01, WAKE_CYC - 100);
    check("rx short", rx[0], 1'b1);
    dom(2'b01, WK);
    check("rx", rx[0], 1'b0);
    check("wake", ws, 2'b01);
    check("int_n", int_n, 1'b0);
    check("mode1", mo1, LTMC_MODE_WAKE);
    clr();
    dom(2'b01, WK);
    check("int_n", int_n, 1'b1);
    check("wake", ws, 2'b00);
    wmode(LTMC_MODE_OFF, LTMC_MODE_OFF);
    check("rx", rx[0], 1'b1);
    wmode(LTMC_MODE_WAKE, LTMC_MODE_OFF);
    dom(2'b01, WK);
    check("int_n", int_n, 1'b0);
    clr();
    $display("test wake done");
    wmode(LTMC_MODE_OFF, LTMC_MODE_OFF);
    chip <= LTMC_CHIP_SLEEP;
    cyc(2);
    wmode(LTMC_MODE_WAKE, LTMC_MODE_OFF);
    rcnt = 0;
    dom(2'b01, WK);
    check("restart", rcnt != 0, 1'b1);
    check("int_n", int_n, 1'b1);
    check("rx", rx[0], 1'b0);
    check("wake", ws, 2'b01);
    clr();
    // Entering stop rearms without a mode write
    chip <= LTMC_CHIP_STOP;
    {wd_dis, wd_on} <= 2'b11;
    cyc(4);
    wcnt = 0;
    dom(2'b01, WK);
    check("watchdog", wcnt != 0, 1'b1);
    check("int_n", int_n, 1'b0);
    clr();
    wmode(LTMC_MODE_OFF, LTMC_MODE_OFF);
    chip <= LTMC_CHIP_FAILSAFE;
    cyc(4);
    check("mode1", mo1, LTMC_MODE_WAKE);
    rcnt = 0;
    dom(2'b01, WK);
    check("restart", rcnt != 0, 1'b1);
    check("int_n", int_n, 1'b1);
    check("rx", rx[0], 1'b0);
    $display("test chip modes done");
    test_done();
  end
endmodule
`default_nettype wire
